/* File: design/ecx_pkg.sv */
/*
 * Package for the extended loopback, indicator and power control register pair.
 * Holds register slots, field positions, reset values, timer figures and the
 * control bundle that the register pair drives into the rest of the port.
 * Assumes a 16-bit management register space with 32 slots and a page select
 * register in the last slot.
 */
package ecx_pkg;

    // -------------------------------------------------------------------------
    // Register slots and page codes
    // -------------------------------------------------------------------------
    localparam logic [4:0] SLOT_LB_LED = 5'h13;   // Loopback and indicator control.
    localparam logic [4:0] SLOT_CTL3 = 5'h14;     // Power and downshift control.
    localparam logic [4:0] SLOT_PAGE = 5'h1f;     // Page select register.
    localparam logic [4:0] SLOT_EXT_LO = 5'h10;   // First paged slot.
    localparam logic [4:0] SLOT_EXT_HI = 5'h1e;   // Last paged slot.
    localparam logic [15:0] PAGE_EXT = 16'h0001;  // Extended page code.
    localparam logic [15:0] PAGE_RST = 16'h0000;  // Page after reset.

    // -------------------------------------------------------------------------
    // Loopback and indicator control fields
    // -------------------------------------------------------------------------
    localparam int LL_LED_HI = 15;     // Indicator three extended mode.
    localparam int LL_LED_LO = 12;     // Indicator zero extended mode.
    localparam int LL_BLINK = 11;      // Blink after reset release.
    localparam int LL_MLB_EN = 10;     // Media-side loopback enable.
    localparam int LL_MLB_HI = 9;      // Media-side loopback mode, high bit.
    localparam int LL_MLB_LO = 8;      // Media-side loopback mode, low bit.
    localparam int LL_CLB_EN = 7;      // MAC-side loopback enable.
    localparam int LL_CLB_HI = 6;      // MAC-side loopback mode, high bit.
    localparam int LL_CLB_LO = 5;      // MAC-side loopback mode, low bit.
    localparam int LL_FLF = 4;         // Fast link failure on pin nine.
    localparam int LL_XO_HI = 3;       // Crossover field, high bit.
    localparam int LL_XO_LO = 2;       // Crossover field, low bit.
    localparam int LL_SD_POL = 0;      // Signal detect polarity.

    // -------------------------------------------------------------------------
    // Power and downshift control fields
    // -------------------------------------------------------------------------
    localparam int C3_CEXT = 15;       // Carrier extension disable.
    localparam int C3_SLP_HI = 14;     // Sleep timer, high bit.
    localparam int C3_SLP_LO = 13;     // Sleep timer, low bit.
    localparam int C3_WAK_HI = 12;     // Wake timer, high bit.
    localparam int C3_WAK_LO = 11;     // Wake timer, low bit.
    localparam int C3_AREV = 9;        // Port address reversal.
    localparam int C3_CLK = 8;         // Clock output frequency select.
    localparam int C3_MED_HI = 7;      // Media status, high bit.
    localparam int C3_MED_LO = 6;      // Media status, low bit.
    localparam int C3_NOPRE = 5;       // No-preamble receive.
    localparam int C3_DS_EN = 4;       // Downshift enable.
    localparam int C3_DS_HI = 3;       // Downshift attempts, high bit.
    localparam int C3_DS_LO = 2;       // Downshift attempts, low bit.
    localparam int C3_DS_ST = 1;       // Downshift status.

    // -------------------------------------------------------------------------
    // Reset values of fields that do not come from the straps
    // -------------------------------------------------------------------------
    localparam logic [1:0] RST_LB_MODE = 2'h0;   // Pad loopback code.
    localparam logic [1:0] RST_XOVER = 2'h0;     // Automatic crossover.
    localparam logic [1:0] RST_SLEEP = 2'h1;     // Two seconds.
    localparam logic [1:0] RST_WAKE = 2'h3;      // Two seconds.
    localparam logic [1:0] RST_DS_CNT = 2'h1;    // Three attempts.

    // -------------------------------------------------------------------------
    // Encodings and timer figures
    // -------------------------------------------------------------------------
    localparam logic [1:0] XO_AUTO = 2'h0;       // Automatic MDI/MDI-X.
    localparam logic [1:0] XO_MDI = 2'h2;        // Forced MDI.
    localparam logic [1:0] XO_MDIX = 2'h3;       // Forced MDI-X.
    localparam logic [1:0] LB_NORMAL_RCLK = 2'h3; // Normal flow, recovered clock.
    localparam logic [11:0] SLEEP_STEP_MS = 12'h03e8; // Sleep step of one second.
    localparam logic [11:0] WAKE_0_MS = 12'h00a0; // 160 ms.
    localparam logic [11:0] WAKE_1_MS = 12'h0190; // 400 ms.
    localparam logic [11:0] WAKE_2_MS = 12'h0320; // 800 ms.
    localparam logic [11:0] WAKE_3_MS = 12'h07d0; // 2 seconds.
    localparam logic [2:0] DS_BASE = 3'h2;        // Attempts for the lowest code.

    // Strap levels sampled once after reset release.
    typedef struct packed {
        logic blink;       // Indicator blink after reset.
        logic sd_pol;      // Signal detect active low.
        logic addr_rev;    // Port address reversal.
        logic clk_sel;     // Clock output 156.25 MHz.
        logic ds_en;       // Downshift enabled.
    } ecx_strap_s;

    // Control bundle driven to the port datapaths.
    typedef struct packed {
        logic [3:0] led_ext;        // Extended mode per indicator, bit 3 is indicator three.
        logic led_reset_blink;      // Blink indicators after reset.
        logic media_lb_en;          // Media-side loopback active.
        logic [1:0] media_lb_mode;  // Media-side loopback mode.
        logic mac_lb_en;            // MAC-side loopback active.
        logic [1:0] mac_lb_mode;    // MAC-side loopback mode.
        logic media_rclk_tx;        // Media transmitter on recovered clock.
        logic mac_rclk_tx;          // MAC transmitter on recovered clock.
        logic far_end_lb;           // Far-end loopback after gating.
        logic isolate;              // Isolate after gating.
        logic auto_mdix;            // Automatic crossover.
        logic force_mdi;            // Forced MDI.
        logic force_mdix;           // Forced MDI-X.
        logic carrier_ext_dis;      // Carrier extension off, newer MAC level.
        logic [11:0] sleep_ms;      // Sleep delay in ms.
        logic [11:0] wake_ms;       // Wake delay in ms.
        logic addr_rev;             // Port address reversal.
        logic clk_out_fast;         // Clock output at 156.25 MHz.
        logic rx_no_preamble;       // Receive without preamble.
        logic downshift_en;         // Downshift enabled.
        logic [2:0] downshift_tries; // Failed attempts before downshift.
    } ecx_ctl_s;

endpackage : ecx_pkg

/* File: design/ecx_regs.sv */
/*
 * Register pair for loopback, indicator, crossover, signal detect, power timer,
 * clock output and downshift control, with the page select register in front.
 * Assumes a management master that issues one-cycle read and write strobes,
 * never both at once, and samples read data the cycle after a read strobe.
 * Strap levels and status inputs are synchronous to clk_sys.
 */
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps

// Functional notes
// (RULE1) Paged slots reach extended set at page one.
// (RULE2) Bits 15:12 enable each indicator's extended mode.
// (RULE3) Bit 11 blink after reset, strap default.
// (RULE4) Bit 10 enables media loopback per bits 9:8.
// (RULE5) Any loopback ignores far-end loopback and isolate.
// (RULE6) Media mode: pad, serial, parallel, recovered clock.
// (RULE7) Bit 7 enables MAC loopback per bits 6:5.
// (RULE8) MAC mode uses same four encodings.
// (RULE9) Bit 4 routes fast link failure to pin nine.
// (RULE10) Crossover: auto, reserved, forced MDI, forced MDI-X.
// (RULE11) Bit 0 signal detect polarity, sticky, strapped.
// (RULE12) Bit 15 disables carrier extension, newer MAC level.
// (RULE13) Sleep delay one to four seconds, default two.
// (RULE14) Wake delay 160 ms to 2 s, default 2 s.
// (RULE15) Bit 8 clock output rate, first port only.
// (RULE16) Bits 7:6 report active media, read only.
// (RULE17) Bit 5 no-preamble receive for 10BASE-T.
// (RULE18) Bit 4 downshift enable, strapped default.
// (RULE19) Bits 3:2 select two to five attempts.
// (RULE20) Bit 1 reports downshift needed or done.
// (RULE21) Reserved bits read zero, ignore writes.
module ecx_regs (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rstn,
    // Management register port.
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Strap levels and port identity.
    input wire ecx_pkg::ecx_strap_s strap_configuration,
    input wire logic first_port,
    // Status from the port.
    input wire logic [1:0] media_status,
    input wire logic downshift_status,
    // Requests gated by loopback.
    input wire logic far_end_lb_req,
    input wire logic isolate_req,
    // Signal detect pin and normalised result.
    input wire logic media_signal_detect_pin,
    output logic signal_detect,
    // General pin nine.
    input wire logic fast_link_fail,
    input wire logic gio9_sw_out,
    input wire logic gio9_sw_oe,
    output logic general_io_pin_nine_out,
    output logic general_io_pin_nine_oe,
    // Control bundle.
    output ecx_pkg::ecx_ctl_s ctl
);

    // -------------------------------------------------------------------------
    // Types and helpers
    // -------------------------------------------------------------------------

    // Whole state of the block.
    typedef struct packed {
        logic loaded;              // Straps have been sampled.
        logic [15:0] page;         // Page select register.
        logic [15:0] lb_led;       // Loopback and indicator register image.
        logic [15:0] ctl3;         // Power and downshift register image.
        logic [15:0] rdata;        // Read data register.
        logic sd;                  // Normalised signal detect.
        logic p9_out;              // Pin nine level.
        logic p9_oe;               // Pin nine enable.
        ecx_pkg::ecx_ctl_s ctl;    // Registered control bundle.
    } ecx_state_s;

    // True when a slot is one of the paged slots mapped to the extended set.
    function automatic logic ext_hit(input logic [15:0] pg, input logic [4:0] a,
                                     input logic [4:0] slot);
        ext_hit = (pg == ecx_pkg::PAGE_EXT) && (a == slot); // RULE1
    endfunction : ext_hit

    // Sleep delay in ms for a code: one second at code zero, one more second per step.
    function automatic logic [11:0] sleep_ms(input logic [1:0] c);
        sleep_ms = 12'(({10'h000, c} + 12'h001) * ecx_pkg::SLEEP_STEP_MS);
    endfunction : sleep_ms

    // Wake delay in ms for a code.
    function automatic logic [11:0] wake_ms(input logic [1:0] c);
        case (c)
            2'h0: wake_ms = ecx_pkg::WAKE_0_MS;
            2'h1: wake_ms = ecx_pkg::WAKE_1_MS;
            2'h2: wake_ms = ecx_pkg::WAKE_2_MS;
            default: wake_ms = ecx_pkg::WAKE_3_MS;
        endcase
    endfunction : wake_ms

    // Writable bit masks; everything else reads as zero, apart from the live status fields.
    localparam logic [15:0] LL_WMASK = 16'hfffd; // RULE21
    localparam logic [15:0] C3_WMASK = 16'hfb3c; // RULE21

    // -------------------------------------------------------------------------
    // Reset release
    // -------------------------------------------------------------------------

    // Reset release through two flip-flops; the design uses the second.
    logic rst_meta;
    logic rst_q;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_q <= rst_meta;
        end
    end

    // -------------------------------------------------------------------------
    // Next-state logic
    // -------------------------------------------------------------------------

    ecx_state_s st;       // Registered state.
    ecx_state_s next_st;  // Next state.

    // Builds the whole next state from the bus strobes, the straps and the inputs.
    always_comb begin
        logic [15:0] ll;
        logic [15:0] c3;
        logic any_lb;
        next_st = st;
        ll = st.lb_led;
        c3 = st.ctl3;
        any_lb = st.lb_led[ecx_pkg::LL_MLB_EN] | st.lb_led[ecx_pkg::LL_CLB_EN];
        // Straps fill their fields once, in the first cycle after release.
        if (!st.loaded) begin
            next_st.loaded = 1'b1;
            ll[ecx_pkg::LL_BLINK] = strap_configuration.blink; // RULE3
            ll[ecx_pkg::LL_SD_POL] = strap_configuration.sd_pol; // RULE11
            c3[ecx_pkg::C3_AREV] = strap_configuration.addr_rev;
            c3[ecx_pkg::C3_CLK] = strap_configuration.clk_sel; // RULE15
            c3[ecx_pkg::C3_DS_EN] = strap_configuration.ds_en; // RULE18
        end else if (reg_wr) begin
            // Page register is plain; paged slots only land at the extended page.
            if (reg_addr == ecx_pkg::SLOT_PAGE) begin
                next_st.page = reg_wdata;
            end
            if (ext_hit(st.page, reg_addr, ecx_pkg::SLOT_LB_LED)) begin
                ll = reg_wdata & LL_WMASK; // RULE21
            end
            if (ext_hit(st.page, reg_addr, ecx_pkg::SLOT_CTL3)) begin
                c3 = reg_wdata & C3_WMASK; // RULE21
            end
        end
        next_st.lb_led = ll;
        next_st.ctl3 = c3;

        // Read data stands only in the cycle after a read strobe.
        next_st.rdata = 16'h0000;
        if (reg_rd) begin
            if (reg_addr == ecx_pkg::SLOT_PAGE) begin
                next_st.rdata = st.page;
            end else if (ext_hit(st.page, reg_addr, ecx_pkg::SLOT_LB_LED)) begin
                next_st.rdata = st.lb_led & LL_WMASK; // RULE21
            end else if (ext_hit(st.page, reg_addr, ecx_pkg::SLOT_CTL3)) begin
                // Status fields come live from the port.
                next_st.rdata = st.ctl3 & C3_WMASK;
                next_st.rdata[ecx_pkg::C3_MED_HI:ecx_pkg::C3_MED_LO] = media_status; // RULE16
                next_st.rdata[ecx_pkg::C3_DS_ST] = downshift_status; // RULE20
            end
        end

        // Control bundle, decoded from the committed register images.
        next_st.ctl.led_ext = st.lb_led[ecx_pkg::LL_LED_HI:ecx_pkg::LL_LED_LO]; // RULE2
        next_st.ctl.led_reset_blink = st.lb_led[ecx_pkg::LL_BLINK]; // RULE3
        next_st.ctl.media_lb_en = st.lb_led[ecx_pkg::LL_MLB_EN]; // RULE4
        next_st.ctl.media_lb_mode = st.lb_led[ecx_pkg::LL_MLB_HI:ecx_pkg::LL_MLB_LO]; // RULE6
        next_st.ctl.mac_lb_en = st.lb_led[ecx_pkg::LL_CLB_EN]; // RULE7
        next_st.ctl.mac_lb_mode = st.lb_led[ecx_pkg::LL_CLB_HI:ecx_pkg::LL_CLB_LO]; // RULE8
        // Code three keeps data flowing but clocks the transmitter from recovery.
        next_st.ctl.media_rclk_tx = st.lb_led[ecx_pkg::LL_MLB_EN] &&
            (st.lb_led[ecx_pkg::LL_MLB_HI:ecx_pkg::LL_MLB_LO] == ecx_pkg::LB_NORMAL_RCLK); // RULE6
        next_st.ctl.mac_rclk_tx = st.lb_led[ecx_pkg::LL_CLB_EN] &&
            (st.lb_led[ecx_pkg::LL_CLB_HI:ecx_pkg::LL_CLB_LO] == ecx_pkg::LB_NORMAL_RCLK); // RULE8
        next_st.ctl.far_end_lb = far_end_lb_req & ~any_lb; // RULE5
        next_st.ctl.isolate = isolate_req & ~any_lb; // RULE5
        // Reserved crossover code falls back to automatic operation.
        next_st.ctl.auto_mdix = (st.lb_led[ecx_pkg::LL_XO_HI:ecx_pkg::LL_XO_LO] !=
            ecx_pkg::XO_MDI) && (st.lb_led[ecx_pkg::LL_XO_HI:ecx_pkg::LL_XO_LO] !=
            ecx_pkg::XO_MDIX); // RULE10
        next_st.ctl.force_mdi = st.lb_led[ecx_pkg::LL_XO_HI:ecx_pkg::LL_XO_LO] ==
            ecx_pkg::XO_MDI; // RULE10
        next_st.ctl.force_mdix = st.lb_led[ecx_pkg::LL_XO_HI:ecx_pkg::LL_XO_LO] ==
            ecx_pkg::XO_MDIX; // RULE10
        next_st.ctl.carrier_ext_dis = st.ctl3[ecx_pkg::C3_CEXT]; // RULE12
        next_st.ctl.sleep_ms = sleep_ms(st.ctl3[ecx_pkg::C3_SLP_HI:ecx_pkg::C3_SLP_LO]); // RULE13
        next_st.ctl.wake_ms = wake_ms(st.ctl3[ecx_pkg::C3_WAK_HI:ecx_pkg::C3_WAK_LO]); // RULE14
        next_st.ctl.addr_rev = st.ctl3[ecx_pkg::C3_AREV];
        next_st.ctl.clk_out_fast = st.ctl3[ecx_pkg::C3_CLK] & first_port; // RULE15
        next_st.ctl.rx_no_preamble = st.ctl3[ecx_pkg::C3_NOPRE]; // RULE17
        next_st.ctl.downshift_en = st.ctl3[ecx_pkg::C3_DS_EN]; // RULE18
        next_st.ctl.downshift_tries = ecx_pkg::DS_BASE +
            {1'b0, st.ctl3[ecx_pkg::C3_DS_HI:ecx_pkg::C3_DS_LO]}; // RULE19

        // Signal detect normalised to active high.
        next_st.sd = media_signal_detect_pin ^ st.lb_led[ecx_pkg::LL_SD_POL]; // RULE11
        // Pin nine carries fast link failure or the software general I/O.
        next_st.p9_out = st.lb_led[ecx_pkg::LL_FLF] ? fast_link_fail : gio9_sw_out; // RULE9
        next_st.p9_oe = st.lb_led[ecx_pkg::LL_FLF] | gio9_sw_oe; // RULE9
    end

    // -------------------------------------------------------------------------
    // State register
    // -------------------------------------------------------------------------

    // Registers the whole state; reset holds the constant defaults.
    always_ff @(posedge clk_sys or negedge rst_q) begin
        if (!rst_q) begin
            st <= '0;
            st.page <= ecx_pkg::PAGE_RST;
            st.lb_led[ecx_pkg::LL_MLB_HI:ecx_pkg::LL_MLB_LO] <= ecx_pkg::RST_LB_MODE;
            st.lb_led[ecx_pkg::LL_CLB_HI:ecx_pkg::LL_CLB_LO] <= ecx_pkg::RST_LB_MODE;
            st.lb_led[ecx_pkg::LL_XO_HI:ecx_pkg::LL_XO_LO] <= ecx_pkg::RST_XOVER;
            st.ctl3[ecx_pkg::C3_SLP_HI:ecx_pkg::C3_SLP_LO] <= ecx_pkg::RST_SLEEP; // RULE13
            st.ctl3[ecx_pkg::C3_WAK_HI:ecx_pkg::C3_WAK_LO] <= ecx_pkg::RST_WAKE; // RULE14
            st.ctl3[ecx_pkg::C3_DS_HI:ecx_pkg::C3_DS_LO] <= ecx_pkg::RST_DS_CNT; // RULE19
        end else begin
            st <= next_st;
        end
    end

    // Outputs come straight from the state flops.
    assign reg_rdata = st.rdata;
    assign signal_detect = st.sd;
    assign general_io_pin_nine_out = st.p9_out;
    assign general_io_pin_nine_oe = st.p9_oe;
    assign ctl = st.ctl;

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------

    // Paged writes away from the extended page leave the loopback image alone.
    property p_page_gate;
        @(posedge clk_sys) disable iff (!rst_q)
        (st.loaded && reg_wr && reg_addr == ecx_pkg::SLOT_LB_LED &&
         st.page != ecx_pkg::PAGE_EXT) |=> $stable(st.lb_led);
    endproperty
    a_page_gate: assert property (p_page_gate) else $error("paged write leaked"); // RULE1

    // Indicator enables follow a write two cycles later.
    property p_led;
        @(posedge clk_sys) disable iff (!rst_q)
        (st.loaded && reg_wr && ext_hit(st.page, reg_addr, ecx_pkg::SLOT_LB_LED))
        |=> ##1 ctl.led_ext == $past(reg_wdata[15:12], 2);
    endproperty
    a_led: assert property (p_led) else $error("indicator mode mismatch"); // RULE2

    // While any loopback is on, far-end loopback and isolate stay low.
    property p_lb_gate;
        @(posedge clk_sys) disable iff (!rst_q)
        (st.lb_led[ecx_pkg::LL_MLB_EN] || st.lb_led[ecx_pkg::LL_CLB_EN])
        |=> !ctl.far_end_lb && !ctl.isolate;
    endproperty
    a_lb_gate: assert property (p_lb_gate) else $error("loopback gating failed"); // RULE5

    // Pin nine is driven with the failure flag when routed.
    property p_pin9;
        @(posedge clk_sys) disable iff (!rst_q)
        st.lb_led[ecx_pkg::LL_FLF] |=> general_io_pin_nine_oe &&
            general_io_pin_nine_out == $past(fast_link_fail);
    endproperty
    a_pin9: assert property (p_pin9) else $error("pin nine not routed"); // RULE9

    // Exactly one crossover output is active once the straps are loaded.
    property p_xover;
        @(posedge clk_sys) disable iff (!rst_q)
        $onehot({ctl.auto_mdix, ctl.force_mdi, ctl.force_mdix}) || !st.loaded;
    endproperty
    a_xover: assert property (p_xover) else $error("crossover not one-hot"); // RULE10

    // Clock output stays slow on any port but the first.
    property p_clk_port;
        @(posedge clk_sys) disable iff (!rst_q)
        !first_port |=> !ctl.clk_out_fast;
    endproperty
    a_clk_port: assert property (p_clk_port) else $error("clock select off port"); // RULE15

    // Read data reports live media and downshift status.
    property p_status;
        @(posedge clk_sys) disable iff (!rst_q)
        (reg_rd && ext_hit(st.page, reg_addr, ecx_pkg::SLOT_CTL3)) |=>
            reg_rdata[7:6] == $past(media_status) && reg_rdata[1] == $past(downshift_status);
    endproperty
    a_status: assert property (p_status) else $error("status read mismatch"); // RULE16

    // Reserved bits 10 and 0 of the power register never read as one.
    property p_resv;
        @(posedge clk_sys) disable iff (!rst_q)
        $past(reg_rd && ext_hit(st.page, reg_addr, ecx_pkg::SLOT_CTL3)) |->
            reg_rdata[ecx_pkg::C3_AREV + 1] == 1'b0 && reg_rdata[0] == 1'b0;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bit set"); // RULE21

    // Downshift attempt count stays within two to five.
    property p_ds;
        @(posedge clk_sys) disable iff (!rst_q)
        st.loaded |=> ctl.downshift_tries >= 3'h2 && ctl.downshift_tries <= 3'h5;
    endproperty
    a_ds: assert property (p_ds) else $error("downshift attempts out of range"); // RULE19

    // Committed writes to each paged register, for the checks below.
    logic wr_ll;
    logic wr_c3;
    assign wr_ll = st.loaded && reg_wr && ext_hit(st.page, reg_addr, ecx_pkg::SLOT_LB_LED);
    assign wr_c3 = st.loaded && reg_wr && ext_hit(st.page, reg_addr, ecx_pkg::SLOT_CTL3);

    // Media loopback enable follows a write two cycles later.
    property p_mlb;
        @(posedge clk_sys) disable iff (!rst_q)
        wr_ll |=> ##1 ctl.media_lb_en == $past(reg_wdata[10], 2);
    endproperty
    a_mlb: assert property (p_mlb) else $error("media loopback mismatch"); // RULE4

    // MAC loopback enable follows a write two cycles later.
    property p_clb;
        @(posedge clk_sys) disable iff (!rst_q)
        wr_ll |=> ##1 ctl.mac_lb_en == $past(reg_wdata[7], 2);
    endproperty
    a_clb: assert property (p_clb) else $error("MAC loopback mismatch"); // RULE7

    // Signal detect follows the pin under the polarity just written.
    property p_sdpol;
        @(posedge clk_sys) disable iff (!rst_q)
        wr_ll |=> ##1 signal_detect == ($past(media_signal_detect_pin) ^ $past(reg_wdata[0], 2));
    endproperty
    a_sdpol: assert property (p_sdpol) else $error("signal detect polarity mismatch"); // RULE11

    // Carrier extension disable follows a write two cycles later.
    property p_cext;
        @(posedge clk_sys) disable iff (!rst_q)
        wr_c3 |=> ##1 ctl.carrier_ext_dis == $past(reg_wdata[15], 2);
    endproperty
    a_cext: assert property (p_cext) else $error("carrier extension mismatch"); // RULE12

    // Downshift enable follows a write two cycles later.
    property p_dsen;
        @(posedge clk_sys) disable iff (!rst_q)
        wr_c3 |=> ##1 ctl.downshift_en == $past(reg_wdata[4], 2);
    endproperty
    a_dsen: assert property (p_dsen) else $error("downshift enable mismatch"); // RULE18

endmodule : ecx_regs

/* File: sim/ecx_port_model.sv */
/* Port-side model: strap levels and port status. Assumes the bench selects the phase. */
`timescale 1ns/100ps
module ecx_port_model (
    // Phase select from the bench.
    input wire logic busy_port,
    // Levels toward the register pair.
    output ecx_pkg::ecx_strap_s straps,
    output logic [1:0] media,
    output logic ds_flag,
    output logic sd_pin,
    output logic flf
);
    // Straps stay fixed; status follows the phase so read-only fields change.
    assign straps = '{blink: 1'b1, sd_pol: 1'b1, addr_rev: 1'b0, clk_sel: 1'b1, ds_en: 1'b1};
    assign media = busy_port ? 2'h2 : 2'h1;
    assign ds_flag = busy_port;
    assign sd_pin = 1'b1;
    assign flf = 1'b1;
endmodule : ecx_port_model

/* File: sim/tb_top.sv */
/* Bench for the register pair. Assumes one clock and the one-cycle register port. */
`timescale 1ns/100ps
module tb_top;
    logic clk_sys = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, busy = 1'b0;
    logic req = 1'b1, fport = 1'b1, sw_oe = 1'b1, sw_out = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic [1:0] media;
    logic ds_flag, sd_pin, flf, sd, p9_out, p9_oe;
    ecx_pkg::ecx_strap_s straps;
    ecx_pkg::ecx_ctl_s ctl;
    int n_mismatch = 0, num_checks = 0, cyc = 0;
    always #5 clk_sys = ~clk_sys;
    ecx_port_model u_port (.busy_port(busy), .straps(straps), .media(media),
        .ds_flag(ds_flag), .sd_pin(sd_pin), .flf(flf));
    ecx_regs u_dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .strap_configuration(straps), .first_port(fport), .media_status(media),
        .downshift_status(ds_flag), .far_end_lb_req(req), .isolate_req(req),
        .media_signal_detect_pin(sd_pin), .signal_detect(sd), .fast_link_fail(flf),
        .gio9_sw_out(sw_out), .gio9_sw_oe(sw_oe), .general_io_pin_nine_out(p9_out),
        .general_io_pin_nine_oe(p9_oe), .ctl(ctl));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd
    // Loopback gating, indicators, pin nine, polarity and every mode code.
    task automatic t_lb;
        wr(5'h13, 16'hffff);
        rd(5'h13, 16'hfffd);
        chk({ctl.led_ext, ctl.media_lb_en, ctl.mac_lb_en, ctl.media_rclk_tx, ctl.mac_rclk_tx,
            ctl.far_end_lb, ctl.isolate, ctl.force_mdix, ctl.auto_mdix, ctl.led_reset_blink,
            p9_oe, p9_out, sd}, 16'hff2e);
        for (int i = 0; i < 4; i++) begin
            wr(5'h13, {5'h00, 1'b1, i[1:0], 1'b1, i[1:0], 1'b0, i[1:0], 2'h0});
            chk({8'h00, ctl.media_lb_mode, ctl.mac_lb_mode, ctl.media_rclk_tx, ctl.force_mdi,
                ctl.force_mdix, ctl.auto_mdix}, {8'h00, i[1:0], i[1:0], i == 3, i == 2,
                i == 3, i < 2});
        end
        wr(5'h13, 16'h0000);
        chk({ctl.far_end_lb, ctl.isolate, ctl.media_lb_en, p9_oe, p9_out, sd, 10'h000},
            16'hd400);
    endtask : t_lb
    // Timers, downshift, clock rate and read-only status.
    task automatic t_ctl3;
        busy <= 1'b1;
        wr(5'h14, 16'hffff);
        rd(5'h14, 16'hfbbe);
        chk({ctl.sleep_ms, ctl.downshift_tries, ctl.clk_out_fast}, 16'hfa0b);
        chk({ctl.carrier_ext_dis, ctl.rx_no_preamble, ctl.downshift_en, ctl.addr_rev,
            ctl.wake_ms}, 16'hf7d0);
        @(posedge clk_sys) fport <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 chk(ctl.clk_out_fast, 16'h0000);
        fport <= 1'b1;
        wr(5'h14, 16'h0000);
        chk({ctl.sleep_ms, ctl.downshift_tries, ctl.downshift_en}, 16'h3e84);
        chk({4'h0, ctl.wake_ms}, 16'h00a0);
    endtask : t_ctl3
    task automatic report_and_stop;
        if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        wr(5'h13, 16'hffff);
        rd(5'h13, 16'h0000);
        wr(5'h1f, 16'h0001);
        rd(5'h13, 16'h0801);
        rd(5'h14, 16'h3954);
        t_lb();
        t_ctl3();
        report_and_stop();
    end
endmodule : tb_top
